// ==== hw/ramp_pkg.sv ====
/*
  Register map, field layout and reset values of the automatic frequency
  ramp generator. Assumes a 32-bit APB slave with word-aligned registers.
*/
`default_nettype none
package ramp_pkg;
  // ***************************************************************
  // register offsets (byte addresses)
  // ***************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LIMIT_HIGH = 8'h04;
  localparam logic [7:0] OFS_LIMIT_LOW = 8'h08;
  localparam logic [7:0] OFS_LIMIT_EXT = 8'h0C;
  localparam logic [7:0] OFS_THRESH = 8'h10;
  localparam logic [7:0] OFS_PAUSE = 8'h14;
  localparam logic [7:0] OFS_P0_STEP = 8'h18;
  localparam logic [7:0] OFS_P0_CFG = 8'h1C;
  localparam logic [7:0] OFS_P1_STEP = 8'h20;
  localparam logic [7:0] OFS_P1_CFG = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_OFFSET = 8'h2C;
  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PIN_BIT = 1;
  localparam int CTRL_SCALE_LSB = 4;
  localparam int SCALE_W = 4;
  localparam int CTRL_DIV_LSB = 8;
  localparam int DIV_W = 2;
  localparam int EXT_HIGH_BIT = 0;
  localparam int EXT_LOW_BIT = 1;
  localparam int CFG_COUNT_LSB = 0;
  localparam int COUNT_W = 17;
  localparam int CFG_HALF_BIT = 17;
  localparam int CFG_SUCC_BIT = 18;
  localparam int CFG_ADV_BIT = 19;
  localparam int CFG_RST_BIT = 20;
  localparam int STEP_W = 30;
  localparam int OFS_W = 33;
  localparam int PAUSE_W = 16;
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_PAUSED_BIT = 1;
  localparam int ST_HOLD_BIT = 2;
  localparam int ST_RUN_BIT = 3;
  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [OFS_W-1:0] LIMIT_HIGH_RST = 33'h0_FFFF_FFFF;
  localparam logic [OFS_W-1:0] LIMIT_LOW_RST = 33'h1_0000_0000;
  localparam logic [31:0] THRESH_RST = 32'hFFFF_FFFF;
  localparam logic [PAUSE_W-1:0] PAUSE_RST = 16'h0000;
  localparam logic [STEP_W-1:0] STEP_RST = 30'h0000_0000;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
endpackage : ramp_pkg
`default_nettype wire

// ==== hw/pause_if.sv ====
/*
  Handshake between the ramp sequencer and the recalibration pause timer.
  Assumes both ends run on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface pause_if;
  logic start;
  logic done;
  modport seq (output start, input done);
  modport timer (input start, output done);
endinterface : pause_if
`default_nettype wire

// ==== hw/recal_pause.sv ====
/*
  Recalibration pause timer: counts reference-oscillator ticks up to
  pause_count * 2^scale * 2^div, then waits for the VCO calibration to end.
  Assumes osc_tick and cal_busy are already synchronised to pclk, and that
  the calibration engine raises cal_busy after each start.
*/
`timescale 1ns/1ps
`default_nettype none
module recal_pause (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // timing sources
  input wire logic osc_tick,
  input wire logic cal_busy,
  // settings
  input wire logic [ramp_pkg::PAUSE_W-1:0] pause_count,
  input wire logic [ramp_pkg::SCALE_W-1:0] scale,
  input wire logic [ramp_pkg::DIV_W-1:0] div,
  // handshake
  pause_if.timer pif
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COUNT = 2'b01,
    ST_WAIT = 2'b10
  } pause_e;

  pause_e state;
  logic [39:0] target;
  logic [39:0] ticks;
  logic cal_seen;

  // ***************************************************************
  // pause sequencing
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      target <= 40'h00_0000_0000;
      ticks <= 40'h00_0000_0000;
      cal_seen <= 1'b0;
      pif.done <= 1'b0;
    end else begin
      pif.done <= 1'b0;
      if (cal_busy) begin
        cal_seen <= 1'b1;
      end
      unique case (state)
        ST_IDLE: begin
          if (pif.start) begin
            // minimum pause in oscillator ticks
            target <= 40'({24'h00_0000, pause_count} << (scale + 5'(div))); // R14
            ticks <= 40'h00_0000_0000;
            cal_seen <= 1'b0;
            state <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (ticks >= target) begin
            state <= ST_WAIT;
          end else if (osc_tick) begin
            ticks <= ticks + 40'h00_0000_0001; // R14
          end
        end
        ST_WAIT: begin
          // a short programmed pause stretches to the real calibration
          if (cal_seen && !cal_busy) begin // R15
            pif.done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  property p_min_pause;
    @(posedge pclk) disable iff (!presetn)
      pif.done |-> $past(ticks) >= $past(target);
  endproperty
  a_min_pause: assert property (p_min_pause) else $error("pause ended early"); // R14

  property p_cal_extends;
    @(posedge pclk) disable iff (!presetn)
      (state == ST_WAIT && cal_busy) |=> !pif.done;
  endproperty
  a_cal_extends: assert property (p_cal_extends) else $error("pause ended mid cal"); // R15
endmodule : recal_pause
`default_nettype wire

// ==== hw/ramp_gen.sv ====
/*
  Automatic frequency ramp generator with an APB register file. Steps a
  33-bit fractional offset once per phase-detector tick (every second tick at half rate), chains two ramp
  profiles, clamps to the limits and pauses for VCO recalibration.
  Assumes pd_clk_in, osc_clk_in and cal_busy are asynchronous pins and
  that the calibration engine raises cal_busy after each cal_start.
*/
// Contract
// R01: ramp automatically only when sweep enable is 1 and pin select is 0.
// R02: apply one step per phase detector cycle unless half rate is set.
// R03: two independent profiles, each with own step, length and chaining; one active.
// R04: swept offset never exceeds the upper bound setting.
// R05: swept offset never falls below the lower bound setting.
// R06: step is scaled frequency change; negatives are 2^30 minus magnitude.
// R07: accumulated change beyond threshold starts a VCO calibration.
// R08: software should keep the threshold below 50 MHz of change.
// R09: each profile runs a programmed step count from zero to 2^16.
// R10: half rate bit makes the profile step every second detector cycle.
// R11: a finished profile hands over to its successor profile.
// R12: advance source 0 starts the successor right after the last step.
// R13: restart bit makes the next profile begin from the start frequency.
// R14: pause at least count times 2^scale times 2^div oscillator cycles.
// R15: a pause shorter than the calibration is extended until it ends.
// R16: software should program a minimum pause of about 50 us.
// R17: offset is a signed 33-bit accumulator; steps sign-extended; signed bounds.
`timescale 1ns/1ps
`default_nettype none
module ramp_gen (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // detector and oscillator clocks, as pins
  input wire logic pd_clk_in,
  input wire logic osc_clk_in,
  // calibration engine
  input wire logic cal_busy,
  output logic cal_start,
  // divider
  output logic [ramp_pkg::OFS_W-1:0] ramp_offset
);
  localparam int OW = ramp_pkg::OFS_W;
  localparam int CW = ramp_pkg::COUNT_W;

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [OW-1:0] sext_step(input logic [ramp_pkg::STEP_W-1:0] s);
    sext_step = {{(OW - ramp_pkg::STEP_W){s[ramp_pkg::STEP_W-1]}}, s}; // R17
  endfunction : sext_step

  function automatic logic [OW-1:0] step_mag(input logic [ramp_pkg::STEP_W-1:0] s);
    logic [OW-1:0] v;
    v = sext_step(s);
    step_mag = v[OW-1] ? OW'(~v + 33'h0_0000_0001) : v; // R06
  endfunction : step_mag

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  logic pd_s1, pd_s2, pd_s3;
  logic osc_s1, osc_s2, osc_s3;
  logic busy_s1, busy_s2;
  logic pd_tick, osc_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_s1 <= 1'b0;
      pd_s2 <= 1'b0;
      pd_s3 <= 1'b0;
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
    end else begin
      pd_s1 <= pd_clk_in;
      pd_s2 <= pd_s1;
      pd_s3 <= pd_s2;
      osc_s1 <= osc_clk_in;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      busy_s1 <= cal_busy;
      busy_s2 <= busy_s1;
    end
  end

  assign pd_tick = pd_s2 && !pd_s3;
  assign osc_tick = osc_s2 && !osc_s3;

  // ***************************************************************
  // register file
  // ***************************************************************
  logic [31:0] ctrl;
  logic [OW-1:0] limit_high, limit_low;
  logic [31:0] recal_threshold;
  logic [ramp_pkg::PAUSE_W-1:0] pause_count;
  logic [ramp_pkg::STEP_W-1:0] profile0_step, profile1_step;
  logic [31:0] p0_cfg, p1_cfg;
  logic [31:0] status;
  logic wr_en, setup, hit;
  logic [31:0] next_prdata;

  assign setup = psel && !penable && !pready;
  assign wr_en = psel && penable && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ramp_pkg::CTRL_RST;
      limit_high <= ramp_pkg::LIMIT_HIGH_RST;
      limit_low <= ramp_pkg::LIMIT_LOW_RST;
      recal_threshold <= ramp_pkg::THRESH_RST;
      pause_count <= ramp_pkg::PAUSE_RST;
      profile0_step <= ramp_pkg::STEP_RST;
      profile1_step <= ramp_pkg::STEP_RST;
      p0_cfg <= ramp_pkg::CFG_RST;
      p1_cfg <= ramp_pkg::CFG_RST;
    end else if (wr_en) begin
      unique case (paddr)
        ramp_pkg::OFS_CTRL: ctrl <= pwdata;
        ramp_pkg::OFS_LIMIT_HIGH: limit_high[31:0] <= pwdata;
        ramp_pkg::OFS_LIMIT_LOW: limit_low[31:0] <= pwdata;
        ramp_pkg::OFS_LIMIT_EXT: begin
          limit_high[32] <= pwdata[ramp_pkg::EXT_HIGH_BIT];
          limit_low[32] <= pwdata[ramp_pkg::EXT_LOW_BIT];
        end
        ramp_pkg::OFS_THRESH: recal_threshold <= pwdata;
        ramp_pkg::OFS_PAUSE: pause_count <= pwdata[ramp_pkg::PAUSE_W-1:0];
        ramp_pkg::OFS_P0_STEP: profile0_step <= pwdata[ramp_pkg::STEP_W-1:0];
        ramp_pkg::OFS_P0_CFG: p0_cfg <= pwdata;
        ramp_pkg::OFS_P1_STEP: profile1_step <= pwdata[ramp_pkg::STEP_W-1:0];
        ramp_pkg::OFS_P1_CFG: p1_cfg <= pwdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    hit = 1'b1;
    unique case (paddr)
      ramp_pkg::OFS_CTRL: next_prdata = ctrl;
      ramp_pkg::OFS_LIMIT_HIGH: next_prdata = limit_high[31:0];
      ramp_pkg::OFS_LIMIT_LOW: next_prdata = limit_low[31:0];
      ramp_pkg::OFS_LIMIT_EXT: next_prdata = {30'h0000_0000, limit_low[32], limit_high[32]};
      ramp_pkg::OFS_THRESH: next_prdata = recal_threshold;
      ramp_pkg::OFS_PAUSE: next_prdata = {16'h0000, pause_count};
      ramp_pkg::OFS_P0_STEP: next_prdata = {2'b00, profile0_step};
      ramp_pkg::OFS_P0_CFG: next_prdata = p0_cfg;
      ramp_pkg::OFS_P1_STEP: next_prdata = {2'b00, profile1_step};
      ramp_pkg::OFS_P1_CFG: next_prdata = p1_cfg;
      ramp_pkg::OFS_STATUS: next_prdata = status;
      ramp_pkg::OFS_OFFSET: next_prdata = ramp_offset[31:0];
      default: begin
        next_prdata = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
  end

  // no wait state: data is captured in setup so every output is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= !hit || (pwrite && (paddr == ramp_pkg::OFS_STATUS
                                       || paddr == ramp_pkg::OFS_OFFSET));
      end
    end
  end

  // ***************************************************************
  // active profile selection
  // ***************************************************************
  logic run;
  logic active;
  logic [31:0] cur_cfg;
  logic [ramp_pkg::STEP_W-1:0] cur_step;
  logic [CW-1:0] cur_count;
  logic cur_half, cur_succ, cur_adv, cur_restart;

  assign run = ctrl[ramp_pkg::CTRL_EN_BIT] && !ctrl[ramp_pkg::CTRL_PIN_BIT]; // R01
  assign cur_cfg = active ? p1_cfg : p0_cfg; // R03
  assign cur_step = active ? profile1_step : profile0_step; // R03
  assign cur_count = cur_cfg[ramp_pkg::CFG_COUNT_LSB +: CW];
  assign cur_half = cur_cfg[ramp_pkg::CFG_HALF_BIT];
  assign cur_succ = cur_cfg[ramp_pkg::CFG_SUCC_BIT];
  assign cur_adv = cur_cfg[ramp_pkg::CFG_ADV_BIT];
  assign cur_restart = cur_cfg[ramp_pkg::CFG_RST_BIT];

  // ***************************************************************
  // stepping decisions
  // ***************************************************************
  logic paused, hold, half_phase;
  logic [CW-1:0] steps_done;
  logic [OW-1:0] acc_change;
  logic step_due, step_fire, last_step, finish, recal;
  logic [OW-1:0] sum, next_offset, next_acc;

  assign step_due = run && pd_tick && !paused && !hold;
  // a zero-length profile takes no step
  assign step_fire = step_due && cur_count != '0 && (!cur_half || half_phase); // R02 R10
  assign last_step = cur_count == '0 || (step_fire && steps_done + 17'h0_0001 == cur_count); // R09
  assign finish = step_due && last_step && !cur_adv; // R12
  assign sum = OW'(ramp_offset + sext_step(cur_step)); // R17

  always_comb begin
    next_offset = sum;
    if ($signed(next_offset) > $signed(limit_high)) begin
      next_offset = limit_high; // R04
    end
    if ($signed(next_offset) < $signed(limit_low)) begin
      next_offset = limit_low; // R05
    end
  end

  assign next_acc = OW'(acc_change + step_mag(cur_step));
  assign recal = step_fire && next_acc > {1'b0, recal_threshold}; // R07

  // ***************************************************************
  // offset accumulator
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_offset <= '0;
    end else if (!run) begin
      ramp_offset <= '0; // R01
    end else if (finish && cur_restart) begin
      ramp_offset <= '0; // R13
    end else if (step_fire) begin
      ramp_offset <= next_offset; // R02
    end
  end

  // ***************************************************************
  // profile sequencing
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= 1'b0;
      steps_done <= '0;
      half_phase <= 1'b0;
      hold <= 1'b0;
    end else if (!run) begin
      active <= 1'b0;
      steps_done <= '0;
      half_phase <= 1'b0;
      hold <= 1'b0;
    end else if (finish) begin
      active <= cur_succ; // R11
      steps_done <= '0;
      half_phase <= 1'b0;
    end else if (step_due) begin
      // external advance triggers are not wired; the profile parks
      if (last_step && cur_adv) begin
        hold <= 1'b1;
      end
      if (cur_half) begin
        half_phase <= !half_phase; // R10
      end
      // a parked profile keeps its count below the length
      if (step_fire && !last_step) begin
        steps_done <= steps_done + 17'h0_0001;
      end
    end
  end

  // ***************************************************************
  // recalibration and pause
  // ***************************************************************
  pause_if pif ();

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_change <= '0;
      paused <= 1'b0;
      cal_start <= 1'b0;
      pif.start <= 1'b0;
    end else begin
      cal_start <= recal; // R07
      pif.start <= recal; // R14
      if (!run) begin
        acc_change <= '0;
      end else if (recal) begin
        acc_change <= '0;
      end else if (step_fire) begin
        acc_change <= next_acc;
      end
      if (recal) begin
        paused <= 1'b1; // R14
      end else if (pif.done || !run) begin
        paused <= 1'b0; // R15
      end
    end
  end

  recal_pause u_pause (
    .pclk(pclk),
    .presetn(presetn),
    .osc_tick(osc_tick),
    .cal_busy(busy_s2),
    .pause_count(pause_count),
    .scale(ctrl[ramp_pkg::CTRL_SCALE_LSB +: ramp_pkg::SCALE_W]),
    .div(ctrl[ramp_pkg::CTRL_DIV_LSB +: ramp_pkg::DIV_W]),
    .pif(pif)
  );

  always_comb begin
    status = 32'h0000_0000;
    status[ramp_pkg::ST_ACTIVE_BIT] = active;
    status[ramp_pkg::ST_PAUSED_BIT] = paused;
    status[ramp_pkg::ST_HOLD_BIT] = hold;
    status[ramp_pkg::ST_RUN_BIT] = run;
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  property p_idle_zero;
    @(posedge pclk) disable iff (!presetn)
      !run |=> ramp_offset == '0 && !cal_start;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("offset moved while off"); // R01

  property p_step_each_tick;
    @(posedge pclk) disable iff (!presetn)
      (step_due && !cur_half && cur_count != '0) |-> step_fire;
  endproperty
  a_step_each_tick: assert property (p_step_each_tick) else $error("tick without step"); // R02

  property p_upper;
    @(posedge pclk) disable iff (!presetn)
      ($signed(limit_low) <= $signed(limit_high) && step_fire && !finish)
        |=> $signed(ramp_offset) <= $signed(limit_high);
  endproperty
  a_upper: assert property (p_upper) else $error("offset above upper bound"); // R04

  property p_lower;
    @(posedge pclk) disable iff (!presetn)
      ($signed(limit_low) <= $signed(limit_high) && step_fire && !finish)
        |=> $signed(ramp_offset) >= $signed(limit_low);
  endproperty
  a_lower: assert property (p_lower) else $error("offset below lower bound"); // R05

  property p_recal;
    @(posedge pclk) disable iff (!presetn)
      (step_fire && next_acc > {1'b0, recal_threshold}) |=> cal_start ##1 !cal_start;
  endproperty
  a_recal: assert property (p_recal) else $error("missed calibration start"); // R07

  property p_count_bound;
    @(posedge pclk) disable iff (!presetn)
      run && cur_count != '0 |-> steps_done < cur_count;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("step count overrun"); // R09

  property p_half;
    @(posedge pclk) disable iff (!presetn)
      (step_fire && cur_half) |-> half_phase ##1 !half_phase || finish;
  endproperty
  a_half: assert property (p_half) else $error("half rate stepped early"); // R10

  property p_successor;
    @(posedge pclk) disable iff (!presetn)
      finish |=> active == $past(cur_succ) && steps_done == '0;
  endproperty
  a_successor: assert property (p_successor) else $error("wrong successor"); // R11

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
      (finish && cur_restart) |=> ramp_offset == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart kept offset"); // R13

  property p_pause_freeze;
    @(posedge pclk) disable iff (!presetn)
      (paused && run && !pif.done) |=> ramp_offset == $past(ramp_offset);
  endproperty
  a_pause_freeze: assert property (p_pause_freeze) else $error("stepped while paused"); // R14
endmodule : ramp_gen
`default_nettype wire

// ==== verification/cal_engine_model.sv ====
/*
  Far-side model: detector and oscillator clock pins and the VCO
  calibration engine. Assumes the bench shares pclk with it.
*/
`timescale 1ns/1ps
`default_nettype none
module cal_engine_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // calibration
  input wire logic cal_start,
  input wire logic [7:0] cal_len,
  output logic cal_busy,
  // clock pins
  output logic pd_clk_in,
  output logic osc_clk_in
);
  // ****************************
  // pins and busy
  // ****************************
  logic [2:0] div;
  logic [7:0] busy_cnt;
  // free running: detector pclk/8, oscillator pclk/4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div <= 3'h0;
    else div <= div + 3'h1;
  end
  assign pd_clk_in = div[2];
  assign osc_clk_in = div[1];
  // busy length chosen by the bench, so a slow cal can outlast the pause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_cnt <= 8'h00;
    else if (cal_start) busy_cnt <= cal_len;
    else if (busy_cnt != 8'h00) busy_cnt <= busy_cnt - 8'h01;
  end
  assign cal_busy = busy_cnt != 8'h00;
endmodule : cal_engine_model
`default_nettype wire

// ==== verification/auto_frequency_ramp_generator_tb.sv ====
/*
  Self-checking bench for ramp_gen over APB: chaining, limits, pauses.
  Assumes cal_engine_model drives the clock pins and cal_busy.
*/
`timescale 1ns/1ps
`default_nettype none
module auto_frequency_ramp_generator_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [7:0] cal_len = 8'h02;
  logic [31:0] prdata;
  logic pready, pslverr, pd_clk_in, osc_clk_in, cal_busy, cal_start;
  logic [32:0] ramp_offset;
  int err_total = 0;
  int num_checks = 0;
  int cal_seen = 0;
  int gap;
  // p0 +16 x4, p1 -8 x3 with restart winning over its last step
  logic [32:0] seq [8] = '{33'h10, 33'h20, 33'h30, 33'h40, 33'h38, 33'h30, 33'h0, 33'h10};
  ramp_gen DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pd_clk_in(pd_clk_in),
    .osc_clk_in(osc_clk_in), .cal_busy(cal_busy), .cal_start(cal_start),
    .ramp_offset(ramp_offset));
  cal_engine_model far_side (.pclk(pclk), .presetn(presetn), .cal_start(cal_start),
    .cal_len(cal_len), .cal_busy(cal_busy), .pd_clk_in(pd_clk_in), .osc_clk_in(osc_clk_in));
  initial begin
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (cal_start === 1'b1) cal_seen++;
  end
  // ****************************
  // tasks
  // ****************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // read: d is the expected data; ee is the expected pslverr
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
    chk("pslverr", 33'(pslverr), 33'(ee));
    if (!w) chk("prdata", 33'(prdata), 33'(d));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : acc
  task automatic step_to(input logic [32:0] exp);
    logic [32:0] last;
    last = ramp_offset;
    gap = 0;
    do begin
      @(posedge pclk);
      gap++;
    end while (ramp_offset === last && gap < 400);
    if (ramp_offset === last) begin
      err_total++;
      tally_and_finish();
    end
    chk("ramp_offset", ramp_offset, exp);
  endtask : step_to
  // ****************************
  // main sequence
  // ****************************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b0, ramp_pkg::OFS_CTRL, ramp_pkg::CTRL_RST, 1'b0);
    acc(1'b0, ramp_pkg::OFS_LIMIT_EXT, 32'h0000_0002, 1'b0);
    acc(1'b0, ramp_pkg::OFS_THRESH, ramp_pkg::THRESH_RST, 1'b0);
    acc(1'b1, ramp_pkg::OFS_STATUS, 32'h0000_000F, 1'b1);
    acc(1'b0, ramp_pkg::OFS_STATUS, 32'h0000_0000, 1'b0);
    acc(1'b0, 8'h30, 32'h0000_0000, 1'b1);
    acc(1'b1, ramp_pkg::OFS_P0_STEP, 32'h0000_0010, 1'b0);
    acc(1'b1, ramp_pkg::OFS_P0_CFG, 32'h0004_0004, 1'b0);
    acc(1'b1, ramp_pkg::OFS_P1_STEP, 32'h3FFF_FFF8, 1'b0);
    acc(1'b1, ramp_pkg::OFS_P1_CFG, 32'h0010_0003, 1'b0);
    acc(1'b1, ramp_pkg::OFS_CTRL, 32'h0000_0003, 1'b0);
    cyc(40);
    chk("ramp_offset", ramp_offset, 33'h0);
    acc(1'b1, ramp_pkg::OFS_CTRL, 32'h0000_0001, 1'b0);
    foreach (seq[i]) begin
      step_to(seq[i]);
      if (i > 0) chk("step gap", 33'(gap), 33'h8);
    end
    // slow calibration must stretch a short pause
    acc(1'b1, ramp_pkg::OFS_CTRL, 32'h0000_0000, 1'b0);
    acc(1'b1, ramp_pkg::OFS_P0_CFG, 32'h0000_0064, 1'b0);
    acc(1'b1, ramp_pkg::OFS_THRESH, 32'h0000_0028, 1'b0);
    acc(1'b1, ramp_pkg::OFS_PAUSE, 32'h0000_0004, 1'b0);
    cal_len <= 8'h64;
    acc(1'b1, ramp_pkg::OFS_CTRL, 32'h0000_0001, 1'b0);
    step_to(33'h10);
    step_to(33'h20);
    step_to(33'h30);
    acc(1'b0, ramp_pkg::OFS_STATUS, 32'h0000_000A, 1'b0);
    step_to(33'h40);
    chk("slow cal gap", 33'(gap > 90), 33'h1);
    chk("cal starts", 33'(cal_seen), 33'h1);
    // quick calibration: pause of 4 << (1 + 1) oscillator edges
    acc(1'b1, ramp_pkg::OFS_CTRL, 32'h0000_0000, 1'b0);
    cal_len <= 8'h02;
    acc(1'b1, ramp_pkg::OFS_CTRL, 32'h0000_0111, 1'b0);
    step_to(33'h10);
    step_to(33'h20);
    step_to(33'h30);
    step_to(33'h40);
    chk("pause gap", 33'(gap >= 56 && gap < 100), 33'h1);
    acc(1'b1, ramp_pkg::OFS_CTRL, 32'h0000_0000, 1'b0);
    acc(1'b1, ramp_pkg::OFS_THRESH, 32'hFFFF_FFFF, 1'b0);
    acc(1'b1, ramp_pkg::OFS_LIMIT_HIGH, 32'h0000_0028, 1'b0);
    acc(1'b1, ramp_pkg::OFS_LIMIT_LOW, 32'hFFFF_FFE8, 1'b0);
    acc(1'b1, ramp_pkg::OFS_LIMIT_EXT, 32'h0000_0002, 1'b0);
    acc(1'b1, ramp_pkg::OFS_P0_CFG, 32'h0002_0064, 1'b0);
    acc(1'b1, ramp_pkg::OFS_CTRL, 32'h0000_0001, 1'b0);
    step_to(33'h10);
    step_to(33'h20);
    chk("half gap", 33'(gap), 33'h10);
    step_to(33'h28);
    cyc(100);
    chk("ramp_offset", ramp_offset, 33'h28);
    acc(1'b1, ramp_pkg::OFS_CTRL, 32'h0000_0000, 1'b0);
    acc(1'b1, ramp_pkg::OFS_P0_STEP, 32'h3FFF_FFF0, 1'b0);
    acc(1'b1, ramp_pkg::OFS_CTRL, 32'h0000_0001, 1'b0);
    cyc(200);
    chk("ramp_offset", ramp_offset, 33'h1_FFFF_FFE8);
    // advance source 1: one step, then the profile parks
    acc(1'b1, ramp_pkg::OFS_CTRL, 32'h0000_0000, 1'b0);
    acc(1'b1, ramp_pkg::OFS_P0_CFG, 32'h0008_0001, 1'b0);
    acc(1'b1, ramp_pkg::OFS_CTRL, 32'h0000_0001, 1'b0);
    cyc(100);
    acc(1'b0, ramp_pkg::OFS_STATUS, 32'h0000_000C, 1'b0);
    acc(1'b0, ramp_pkg::OFS_OFFSET, 32'hFFFF_FFF0, 1'b0);
    tally_and_finish();
  end
endmodule : auto_frequency_ramp_generator_tb
`default_nettype wire
